// ### design/hcb_top.sv
/*
  Hardware configuration byte block: latches the operating mode from the straps, loads the
  two bytes from non-volatile storage after reset, accepts programmer writes only in a flash
  programming mode, serves reads to the core through an address/data register pair, and
  drives the decoded device controls.
  Assumes storage returns read data in the same cycle as nv_rd_en and nv_rd_addr, and that the straps are
  stable while srst is high.
*/
`timescale 1ns/10ps
// Contract
// - bytes writable only in programming modes
// - 7Fh selects byte zero, 7Eh byte one
// - security clear blocks programming-mode flash access
// - program lock blocks user writes, beats sector
// - sector lock makes reset sector read-only
// - boot ROM enable bit
// - watchdog reset enable bit
// - data flash size code, 000 reserved
// - digital brownout threshold select
// - analog brownout threshold, same mapping
// - analog brownout reset disable bit
// - digital brownout reset disable bit
// - port 0 external bus with strobes
// - port 2 external addressing with strobes
// - leave programming mode only through reset
module hcb_top
  import hcb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  // mode straps sampled during reset
  input wire logic psen_strap,
  input wire logic ale_strap,
  // core special function register access
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // programmer write port
  input wire logic prog_wr_en,
  input wire logic [7:0] prog_wr_addr,
  input wire logic [7:0] prog_wr_data,
  input wire logic mass_erase_done,
  // non-volatile storage
  output logic nv_rd_en,
  output logic [7:0] nv_rd_addr,
  input wire logic [7:0] nv_rd_data,
  output logic nv_wr_en,
  output logic [7:0] nv_wr_addr,
  output logic [7:0] nv_wr_data,
  // status
  output logic config_ready,
  output logic core_hold,
  output logic user_application_mode,
  output logic serial_prog_mode,
  output logic parallel_prog_mode,
  // decoded controls
  output logic flash_prog_blocked,
  output logic prog_mem_write_allow,
  output logic reset_sector_write_allow,
  output logic boot_rom_enable,
  output logic watchdog_reset_enable,
  output logic [2:0] data_flash_size,
  output logic data_flash_reserved,
  output logic data_flash_absent,
  output logic [12:0] digital_brownout_mv,
  output logic [12:0] analog_brownout_mv,
  output logic analog_brownout_reset_en,
  output logic digital_brownout_reset_en,
  output logic port0_ext_bus,
  output logic port2_ext_addr,
  output logic port3_strobes
);

  hcb_mode_t mode; // operating mode held from reset to reset
  hcb_load_t load_state; // loader progress
  logic [7:0] config_byte_zero; // shadow of the first byte
  logic [7:0] config_byte_one; // shadow of the second byte
  logic [7:0] config_address_select; // core-written selector
  logic [7:0] config_data_port; // selected byte as the core sees it
  logic [7:0] next_config_data_port; // value loaded each cycle
  logic prog_mode; // either programming mode
  logic user_mode; // user application mode
  logic prog_hit; // programmer write that is taken
  logic d_flash_prog_blocked; // decode results
  logic d_prog_mem_write_allow;
  logic d_reset_sector_write_allow;
  logic d_boot_rom_on;
  logic d_watchdog_reset_on;
  logic [2:0] d_data_flash_code;
  logic d_data_flash_reserved;
  logic d_data_flash_absent;
  logic [12:0] d_digital_bo_mv;
  logic [12:0] d_analog_bo_mv;
  logic d_analog_bo_reset_on;
  logic d_digital_bo_reset_on;
  logic d_port0_ext_bus;
  logic d_port2_ext_addr;
  logic d_port3_strobes;

  // strap decode used once at reset
  function automatic hcb_mode_t hcb_strap_mode(input logic psen, input logic ale);
    hcb_mode_t m;
    m = HCB_MODE_USER;
    if (!psen && ale) begin
      m = HCB_MODE_SERIAL;
    end else if (psen && !ale) begin
      m = HCB_MODE_PARALLEL;
    end
    return m;
  endfunction : hcb_strap_mode

  // mode flags
  assign prog_mode = (mode != HCB_MODE_USER);
  assign user_mode = (mode == HCB_MODE_USER);

  // programmer write is taken only once loaded and in a programming mode
  assign prog_hit = prog_wr_en & prog_mode & (load_state == HCB_LD_RUN) &
                    ((prog_wr_addr == HCB_CFG_BYTE_ZERO) | (prog_wr_addr == HCB_CFG_BYTE_ONE));

  // mode latch: reloaded only while reset is high, so no other path leaves a mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode <= hcb_strap_mode(psen_strap, ale_strap);
    end
  end

  // loader sequence and shadow bytes
  always_ff @(posedge mclk) begin
    if (srst) begin
      // first read is issued while reset is still high
      load_state <= HCB_LD_CAP0;
      nv_rd_en <= 1'b1;
      nv_rd_addr <= HCB_CFG_BYTE_ZERO;
      config_byte_zero <= HCB_RST_BYTE;
      config_byte_one <= HCB_RST_BYTE;
    end else begin
      unique case (load_state)
        HCB_LD_CAP0: begin
          // capture byte zero, ask for byte one
          config_byte_zero <= nv_rd_data;
          nv_rd_addr <= HCB_CFG_BYTE_ONE;
          load_state <= HCB_LD_CAP1;
        end
        HCB_LD_CAP1: begin
          // capture byte one, loading done
          config_byte_one <= nv_rd_data;
          nv_rd_en <= 1'b0;
          load_state <= HCB_LD_RUN;
        end
        HCB_LD_RUN: begin
          if (mass_erase_done && prog_mode) begin
            // erased storage reads all ones, which lifts the security block but sets both write locks
            config_byte_zero <= HCB_RST_BYTE;
            config_byte_one <= HCB_RST_BYTE;
          end else if (prog_hit) begin
            // byte write from the programmer
            if (prog_wr_addr == HCB_CFG_BYTE_ZERO) begin
              config_byte_zero <= prog_wr_data;
            end else begin
              config_byte_one <= prog_wr_data;
            end
          end
        end
      endcase
    end
  end

  // storage write strobe follows a taken programmer write by one cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      nv_wr_en <= 1'b0;
      nv_wr_addr <= HCB_ZERO_BYTE;
      nv_wr_data <= HCB_ZERO_BYTE;
    end else begin
      nv_wr_en <= prog_hit && !mass_erase_done;
      if (prog_hit) begin
        nv_wr_addr <= prog_wr_addr;
        nv_wr_data <= prog_wr_data;
      end
    end
  end

  // status: core held until the bytes are in place
  always_ff @(posedge mclk) begin
    if (srst) begin
      config_ready <= 1'b0;
      core_hold <= 1'b1;
    end else begin
      config_ready <= (load_state == HCB_LD_CAP1) || config_ready;
      core_hold <= !((load_state == HCB_LD_CAP1) || config_ready);
    end
  end

  // mode outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      user_application_mode <= 1'b0;
      serial_prog_mode <= 1'b0;
      parallel_prog_mode <= 1'b0;
    end else begin
      user_application_mode <= user_mode;
      serial_prog_mode <= (mode == HCB_MODE_SERIAL);
      parallel_prog_mode <= (mode == HCB_MODE_PARALLEL);
    end
  end

  // address select register; writes to the data port are dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      config_address_select <= HCB_RST_CFG_ADDR;
    end else if (sfr_wr_en && sfr_addr == HCB_SFR_CFG_ADDR) begin
      config_address_select <= sfr_wdata;
    end
  end

  // data port source: a byte is visible only in user mode, never writable there
  always_comb begin
    next_config_data_port = HCB_ZERO_BYTE;
    if (user_mode) begin
      if (config_address_select == HCB_CFG_BYTE_ZERO) begin
        next_config_data_port = config_byte_zero;
      end else if (config_address_select == HCB_CFG_BYTE_ONE) begin
        next_config_data_port = config_byte_one;
      end
    end
  end

  // data port register tracks the selected byte
  always_ff @(posedge mclk) begin
    if (srst) begin
      config_data_port <= HCB_RST_CFG_DATA;
    end else begin
      config_data_port <= next_config_data_port;
    end
  end

  // read data, one cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      sfr_rdata <= HCB_ZERO_BYTE;
    end else if (sfr_rd_en) begin
      if (sfr_addr == HCB_SFR_CFG_ADDR) begin
        sfr_rdata <= config_address_select;
      end else if (sfr_addr == HCB_SFR_CFG_DATA) begin
        sfr_rdata <= config_data_port;
      end else begin
        sfr_rdata <= HCB_ZERO_BYTE;
      end
    end
  end

  // field decode
  hcb_decode u_decode (
    .byte_zero(config_byte_zero),
    .byte_one(config_byte_one),
    .user_mode(user_mode),
    .prog_mode(prog_mode),
    .flash_prog_blocked(d_flash_prog_blocked),
    .prog_mem_write_allow(d_prog_mem_write_allow),
    .reset_sector_write_allow(d_reset_sector_write_allow),
    .boot_rom_on(d_boot_rom_on),
    .watchdog_reset_on(d_watchdog_reset_on),
    .data_flash_code(d_data_flash_code),
    .data_flash_reserved(d_data_flash_reserved),
    .data_flash_absent(d_data_flash_absent),
    .digital_bo_mv(d_digital_bo_mv),
    .analog_bo_mv(d_analog_bo_mv),
    .analog_bo_reset_on(d_analog_bo_reset_on),
    .digital_bo_reset_on(d_digital_bo_reset_on),
    .port0_ext_bus(d_port0_ext_bus),
    .port2_ext_addr(d_port2_ext_addr),
    .port3_strobes(d_port3_strobes)
  );

  // registered controls; reset shows the erased defaults
  always_ff @(posedge mclk) begin
    if (srst) begin
      flash_prog_blocked <= 1'b0;
      prog_mem_write_allow <= 1'b0;
      reset_sector_write_allow <= 1'b0;
      boot_rom_enable <= HCB_RST_BYTE[HCB_B0_BOOT_ROM];
      watchdog_reset_enable <= HCB_RST_BYTE[HCB_B0_WDOG_RESET];
      data_flash_size <= HCB_DFLASH_NONE;
      data_flash_reserved <= 1'b0;
      data_flash_absent <= 1'b1;
      digital_brownout_mv <= HCB_BO_MV_CODE3;
      analog_brownout_mv <= HCB_BO_MV_CODE3;
      analog_brownout_reset_en <= 1'b0;
      digital_brownout_reset_en <= 1'b0;
      port0_ext_bus <= 1'b0;
      port2_ext_addr <= 1'b0;
      port3_strobes <= 1'b0;
    end else begin
      flash_prog_blocked <= d_flash_prog_blocked;
      prog_mem_write_allow <= d_prog_mem_write_allow;
      reset_sector_write_allow <= d_reset_sector_write_allow;
      boot_rom_enable <= d_boot_rom_on;
      watchdog_reset_enable <= d_watchdog_reset_on;
      data_flash_size <= d_data_flash_code;
      data_flash_reserved <= d_data_flash_reserved;
      data_flash_absent <= d_data_flash_absent;
      digital_brownout_mv <= d_digital_bo_mv;
      analog_brownout_mv <= d_analog_bo_mv;
      analog_brownout_reset_en <= d_analog_bo_reset_on;
      digital_brownout_reset_en <= d_digital_bo_reset_on;
      port0_ext_bus <= d_port0_ext_bus;
      port2_ext_addr <= d_port2_ext_addr;
      port3_strobes <= d_port3_strobes;
    end
  end

endmodule : hcb_top

// ### pkg/hcb_pkg.sv
/*
  Package for the hardware configuration byte block: register offsets, field positions,
  reset values, mode and loader state types, and the brownout threshold figures.
  Assumes it is compiled ahead of every design file that imports it.
*/
package hcb_pkg;

  // special function register offsets seen by the core
  localparam logic [7:0] HCB_SFR_CFG_ADDR = 8'h93; // config_address_select
  localparam logic [7:0] HCB_SFR_CFG_DATA = 8'h94; // config_data_port

  // configuration space addresses of the two bytes
  localparam logic [7:0] HCB_CFG_BYTE_ZERO = 8'h7F; // config_byte_zero
  localparam logic [7:0] HCB_CFG_BYTE_ONE = 8'h7E; // config_byte_one

  // reset values
  localparam logic [7:0] HCB_RST_CFG_ADDR = 8'h00;
  localparam logic [7:0] HCB_RST_CFG_DATA = 8'h00;
  localparam logic [7:0] HCB_RST_BYTE = 8'hFF; // erased flash reads all ones
  localparam logic [7:0] HCB_ZERO_BYTE = 8'h00; // unmapped reads

  // config_byte_zero field positions
  localparam int HCB_B0_ACCESS_SECURITY = 7; // program_access_security
  localparam int HCB_B0_WRITE_LOCK = 6; // program_write_lock
  localparam int HCB_B0_SECTOR_LOCK = 5; // reset_sector_lock
  localparam int HCB_B0_BOOT_ROM = 4; // boot_rom_enable
  localparam int HCB_B0_WDOG_RESET = 3; // watchdog_reset_enable
  localparam int HCB_B0_DFLASH_MSB = 2; // data_flash_size
  localparam int HCB_B0_DFLASH_LSB = 0;

  // config_byte_one field positions
  localparam int HCB_B1_DIG_LEVEL_MSB = 7; // digital_brownout_level
  localparam int HCB_B1_DIG_LEVEL_LSB = 6;
  localparam int HCB_B1_ANA_LEVEL_MSB = 5; // analog_brownout_level
  localparam int HCB_B1_ANA_LEVEL_LSB = 4;
  localparam int HCB_B1_ANA_BO_DISABLE = 3; // analog_brownout_disable
  localparam int HCB_B1_DIG_BO_DISABLE = 2; // digital_brownout_disable
  localparam int HCB_B1_PORT0_GPIO = 1; // port0_gpio_select
  localparam int HCB_B1_PORT23_GPIO = 0; // port23_gpio_select

  // data flash size codes
  localparam logic [2:0] HCB_DFLASH_RESERVED = 3'h0;
  localparam logic [2:0] HCB_DFLASH_NONE = 3'h7;

  // brownout thresholds in millivolts, by level code
  localparam logic [12:0] HCB_BO_MV_CODE0 = 13'd4500;
  localparam logic [12:0] HCB_BO_MV_CODE1 = 13'd4200;
  localparam logic [12:0] HCB_BO_MV_CODE2 = 13'd2700;
  localparam logic [12:0] HCB_BO_MV_CODE3 = 13'd2500;

  // operating mode latched from the straps at reset
  typedef enum logic [2:0] {
    HCB_MODE_USER = 3'b001,
    HCB_MODE_SERIAL = 3'b010,
    HCB_MODE_PARALLEL = 3'b100
  } hcb_mode_t;

  // loader state
  typedef enum logic [2:0] {
    HCB_LD_CAP0 = 3'b001,
    HCB_LD_CAP1 = 3'b010,
    HCB_LD_RUN = 3'b100
  } hcb_load_t;

endpackage : hcb_pkg

// ### design/hcb_decode.sv
/*
  Combinational decode of the two configuration bytes into named device controls.
  Assumes the caller registers every output before it leaves the block.
*/
`timescale 1ns/10ps
module hcb_decode
  import hcb_pkg::*;
(
  input wire logic [7:0] byte_zero,
  input wire logic [7:0] byte_one,
  input wire logic user_mode,
  input wire logic prog_mode,
  output logic flash_prog_blocked,
  output logic prog_mem_write_allow,
  output logic reset_sector_write_allow,
  output logic boot_rom_on,
  output logic watchdog_reset_on,
  output logic [2:0] data_flash_code,
  output logic data_flash_reserved,
  output logic data_flash_absent,
  output logic [12:0] digital_bo_mv,
  output logic [12:0] analog_bo_mv,
  output logic analog_bo_reset_on,
  output logic digital_bo_reset_on,
  output logic port0_ext_bus,
  output logic port2_ext_addr,
  output logic port3_strobes
);

  // level code to threshold, shared by both supplies
  function automatic logic [12:0] hcb_level_mv(input logic [1:0] code);
    logic [12:0] mv;
    mv = HCB_BO_MV_CODE3;
    unique case (code)
      2'h0: mv = HCB_BO_MV_CODE0;
      2'h1: mv = HCB_BO_MV_CODE1;
      2'h2: mv = HCB_BO_MV_CODE2;
      2'h3: mv = HCB_BO_MV_CODE3;
    endcase
    return mv;
  endfunction : hcb_level_mv

  // field decode
  always_comb begin
    // security clear: programming mode sees no flash until mass erase
    flash_prog_blocked = prog_mode & ~byte_zero[HCB_B0_ACCESS_SECURITY];
    // program memory lock governs user writes and overrides the sector lock
    prog_mem_write_allow = user_mode & ~byte_zero[HCB_B0_WRITE_LOCK];
    reset_sector_write_allow = prog_mem_write_allow & ~byte_zero[HCB_B0_SECTOR_LOCK];
    boot_rom_on = byte_zero[HCB_B0_BOOT_ROM];
    watchdog_reset_on = byte_zero[HCB_B0_WDOG_RESET];
    data_flash_code = byte_zero[HCB_B0_DFLASH_MSB:HCB_B0_DFLASH_LSB];
    data_flash_reserved = (data_flash_code == HCB_DFLASH_RESERVED);
    data_flash_absent = (data_flash_code == HCB_DFLASH_NONE);
    digital_bo_mv = hcb_level_mv(byte_one[HCB_B1_DIG_LEVEL_MSB:HCB_B1_DIG_LEVEL_LSB]);
    analog_bo_mv = hcb_level_mv(byte_one[HCB_B1_ANA_LEVEL_MSB:HCB_B1_ANA_LEVEL_LSB]);
    analog_bo_reset_on = ~byte_one[HCB_B1_ANA_BO_DISABLE];
    digital_bo_reset_on = ~byte_one[HCB_B1_DIG_BO_DISABLE];
    port0_ext_bus = ~byte_one[HCB_B1_PORT0_GPIO];
    port2_ext_addr = ~byte_one[HCB_B1_PORT23_GPIO];
    // either external memory use takes the two strobe pins
    port3_strobes = port0_ext_bus | port2_ext_addr;
  end

endmodule : hcb_decode

// ### test/hcb_nv_model.sv
/*
  Non-volatile storage model for the two configuration bytes, seen from the storage port.
  Assumes read data must track the requested address within the cycle of the request.
*/
`timescale 1ns/10ps
module hcb_nv_model #(
  parameter logic [7:0] INIT0 = 8'hFF, // content of byte zero at power-up
  parameter logic [7:0] INIT1 = 8'hFF // content of byte one at power-up
) (
  input wire logic mclk,
  input wire logic nv_rd_en,
  input wire logic [7:0] nv_rd_addr,
  output logic [7:0] nv_rd_data,
  input wire logic nv_wr_en,
  input wire logic [7:0] nv_wr_addr,
  input wire logic [7:0] nv_wr_data
);
  logic [7:0] mem [2] = '{INIT1, INIT0}; // index 1 holds byte zero, index 0 byte one
  logic [7:0] last = 8'h00; // last value put on the read bus

  // accepted writes land in storage; other addresses never reach this port
  always_ff @(posedge mclk) begin
    if (nv_wr_en) begin
      mem[nv_wr_addr[0]] <= nv_wr_data;
    end
    last <= nv_rd_data;
  end

  // outside a read the bus shows the inverse of its last value, never stale data
  always_comb begin
    nv_rd_data = nv_rd_en ? mem[nv_rd_addr[0]] : ~last;
  end
endmodule : hcb_nv_model

// ### test/hcb_top_assertions.sv
/*
  Concurrent checks on the ports of the configuration byte block.
  Assumes one clock domain and the synchronous reset of the block.
*/
`timescale 1ns/10ps
module hcb_top_assertions
  import hcb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic prog_wr_en,
  input wire logic [7:0] prog_wr_addr,
  input wire logic [7:0] prog_wr_data,
  input wire logic mass_erase_done,
  input wire logic nv_wr_en,
  input wire logic [7:0] nv_wr_data,
  input wire logic config_ready,
  input wire logic core_hold,
  input wire logic user_application_mode,
  input wire logic serial_prog_mode,
  input wire logic parallel_prog_mode,
  input wire logic prog_mem_write_allow,
  input wire logic reset_sector_write_allow,
  input wire logic port0_ext_bus,
  input wire logic port2_ext_addr,
  input wire logic port3_strobes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic accept; // programmer write that must be taken
  logic acc_one; // taken write aimed at byte one

  // a programmer write counts only in a programming mode after loading
  assign accept = prog_wr_en && (serial_prog_mode || parallel_prog_mode) && config_ready && !mass_erase_done
    && (prog_wr_addr == HCB_CFG_BYTE_ZERO || prog_wr_addr == HCB_CFG_BYTE_ONE);
  assign acc_one = accept && prog_wr_addr == HCB_CFG_BYTE_ONE;

  chk_user_no_write: assert property (user_application_mode |-> !nv_wr_en)
    else $error("storage written in user mode");
  chk_prog_wr_pulse: assert property (accept |=> nv_wr_en && nv_wr_data == $past(prog_wr_data))
    else $error("programmer write not passed to storage");
  chk_unmapped_zero: assert property (
    sfr_rd_en && sfr_addr != HCB_SFR_CFG_ADDR && sfr_addr != HCB_SFR_CFG_DATA |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_stands: assert property (!sfr_rd_en |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  chk_load_order: assert property ($fell(srst) |-> !config_ready ##1 !config_ready ##1 config_ready)
    else $error("load did not finish on the second edge");
  chk_hold_ready: assert property (core_hold != config_ready)
    else $error("core hold disagrees with ready");
  // mode outputs load on the first edge after release, so skip the edge that sees that step
  chk_mode_kept: assert property (
    !$past(srst) && !$past(srst, 2) |-> $stable({user_application_mode, serial_prog_mode, parallel_prog_mode}))
    else $error("mode changed without reset");
  chk_lock_priority: assert property (
    reset_sector_write_allow |-> prog_mem_write_allow && user_application_mode)
    else $error("write permission outside lock order");
  chk_strobe_or: assert property (port3_strobes == (port0_ext_bus || port2_ext_addr))
    else $error("strobe pins disagree with bus select");
  chk_byte1_ports: assert property (
    acc_one |-> ##2 port0_ext_bus == !$past(prog_wr_data[1], 2) && port2_ext_addr == !$past(prog_wr_data[0], 2))
    else $error("port select not taken from byte one");
endmodule : hcb_top_assertions

bind hcb_top hcb_top_assertions u_hcb_chk (.*);

// ### test/hcb_top_test.sv
/*
  Self-checking bench for the configuration byte block: user, serial and parallel resets.
  Assumes the storage model and the checker are compiled beside the design.
*/
`timescale 1ns/10ps
module hcb_top_test;
  import hcb_pkg::*;
  logic mclk = 0, srst = 1, psen_strap = 1, ale_strap = 1, sfr_wr_en = 0, sfr_rd_en = 0;
  logic prog_wr_en = 0, mass_erase_done = 0, nv_rd_en, nv_wr_en, config_ready, core_hold;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, prog_wr_addr = 0, prog_wr_data = 0;
  logic [7:0] nv_rd_data, sfr_rdata, nv_rd_addr, nv_wr_addr, nv_wr_data;
  logic user_application_mode, serial_prog_mode, parallel_prog_mode, flash_prog_blocked;
  logic prog_mem_write_allow, reset_sector_write_allow, boot_rom_enable, watchdog_reset_enable;
  logic data_flash_reserved, data_flash_absent, analog_brownout_reset_en, digital_brownout_reset_en;
  logic port0_ext_bus, port2_ext_addr, port3_strobes;
  logic [2:0] data_flash_size;
  logic [12:0] digital_brownout_mv, analog_brownout_mv;
  logic [12:0] mv_tab [4] = '{HCB_BO_MV_CODE0, HCB_BO_MV_CODE1, HCB_BO_MV_CODE2, HCB_BO_MV_CODE3};
  int miscompares = 0, n_tests = 0;

  always #20 mclk = ~mclk; // 25 MHz
  hcb_top DUT (.*);
  hcb_nv_model #(.INIT0(8'h2A), .INIT1(8'h9D)) u_nv (.*);

  // verdict, reached from the main sequence or the hang guard
  task summarize;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // reset with straps held, then wait for the load under a bound
  task do_reset(input logic p, input logic a);
    @(negedge mclk);
    srst = 1;
    psen_strap = p;
    ale_strap = a;
    repeat (5) @(negedge mclk);
    srst = 0;
    for (int i = 0; i < 20 && config_ready !== 1'b1; i++) @(negedge mclk);
    chk(config_ready, 1, "load timeout");
    if (config_ready !== 1'b1) summarize();
    repeat (2) @(negedge mclk);
  endtask : do_reset

  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_wr_en = 1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge mclk);
    sfr_wr_en = 0;
  endtask : sfr_wr

  task sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr_rd_en = 1;
    sfr_addr = a;
    @(negedge mclk);
    sfr_rd_en = 0;
    chk(sfr_rdata, exp, "sfr read");
  endtask : sfr_rd

  // one programmer write, then let the decode settle
  task prog_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    prog_wr_en = 1;
    prog_wr_addr = a;
    prog_wr_data = d;
    @(negedge mclk);
    prog_wr_en = 0;
    repeat (2) @(negedge mclk);
  endtask : prog_wr

  task check_byte0(input logic [7:0] b);
    chk(boot_rom_enable, b[4], "boot rom");
    chk(watchdog_reset_enable, b[3], "watchdog");
    chk({data_flash_size, data_flash_reserved, data_flash_absent},
        {b[2:0], b[2:0] == 3'h0, b[2:0] == 3'h7}, "dflash");
  endtask : check_byte0

  task check_byte1(input logic [7:0] b);
    chk(digital_brownout_mv, mv_tab[b[7:6]], "dig level");
    chk(analog_brownout_mv, mv_tab[b[5:4]], "ana level");
    // bits inverted one by one so the 16-bit argument does not widen the inversion
    chk({analog_brownout_reset_en, digital_brownout_reset_en}, {~b[3], ~b[2]}, "bo reset");
    chk({port0_ext_bus, port2_ext_addr, port3_strobes}, {~b[1], ~b[0], ~(b[1] & b[0])}, "ports");
  endtask : check_byte1

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("CHECK FAILED t=%0t run limit reached", $time);
    summarize();
  end

  initial begin
    do_reset(1, 1);
    chk(user_application_mode, 1, "user mode");
    check_byte0(8'h2A);
    check_byte1(8'h9D);
    chk({flash_prog_blocked, prog_mem_write_allow, reset_sector_write_allow}, 3'b010, "locks");
    sfr_rd(HCB_SFR_CFG_ADDR, 8'h00);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h00);
    sfr_wr(HCB_SFR_CFG_ADDR, HCB_CFG_BYTE_ZERO);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h2A);
    sfr_wr(HCB_SFR_CFG_ADDR, HCB_CFG_BYTE_ONE);
    sfr_wr(HCB_SFR_CFG_DATA, 8'hFF);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h9D);
    sfr_rd(HCB_SFR_CFG_ADDR, 8'h7E);
    sfr_rd(8'h95, 8'h00);
    sfr_wr(HCB_SFR_CFG_ADDR, 8'h55);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h00);
    prog_wr(HCB_CFG_BYTE_ZERO, 8'h00);
    sfr_wr(HCB_SFR_CFG_ADDR, HCB_CFG_BYTE_ZERO);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h2A);
    $display("test user read done");
    do_reset(0, 1);
    chk(serial_prog_mode, 1, "serial mode");
    sfr_wr(HCB_SFR_CFG_ADDR, HCB_CFG_BYTE_ZERO);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h00);
    for (int c = 0; c < 4; c++) begin
      prog_wr(HCB_CFG_BYTE_ONE, {c[1:0], c[1:0], c[1:0], c[1:0]});
      check_byte1({c[1:0], c[1:0], c[1:0], c[1:0]});
    end
    for (int c = 0; c < 8; c++) begin
      prog_wr(HCB_CFG_BYTE_ZERO, {5'h0B, c[2:0]});
      check_byte0({5'h0B, c[2:0]});
      chk({flash_prog_blocked, prog_mem_write_allow}, 2'b10, "security");
    end
    @(negedge mclk);
    psen_strap = 1;
    ale_strap = 1;
    mass_erase_done = 1;
    @(negedge mclk);
    mass_erase_done = 0;
    repeat (2) @(negedge mclk);
    chk({serial_prog_mode, flash_prog_blocked}, 2'b10, "erase");
    check_byte1(8'hFF);
    // both locks cleared so the next user reset grants reset sector writes
    prog_wr(HCB_CFG_BYTE_ZERO, 8'h85);
    prog_wr(HCB_CFG_BYTE_ONE, 8'h6C);
    $display("test serial program done");
    do_reset(1, 0);
    chk({parallel_prog_mode, prog_mem_write_allow}, 2'b10, "parallel");
    check_byte0(8'h85);
    check_byte1(8'h6C);
    do_reset(1, 1);
    chk({flash_prog_blocked, prog_mem_write_allow, reset_sector_write_allow}, 3'b011, "unlocked");
    sfr_wr(HCB_SFR_CFG_ADDR, HCB_CFG_BYTE_ONE);
    sfr_rd(HCB_SFR_CFG_DATA, 8'h6C);
    $display("test reload done");
    summarize();
  end
endmodule : hcb_top_test
